// ===== scl_pkg.sv
// Package for the synthesizer calibration and lock control block
package scl_pkg;
    localparam int          WORD_W        = 16;
    localparam int          PUMP_W        = 4;
    localparam int          SWEEP_W       = 4;
    localparam int          FRAC_DEN_LOG2 = 13;              // 8192
    localparam logic [1:0]  DIV_LOW_BAND  = 2'h1;            // Divider code for divide by 4
    localparam logic [1:0]  DIV_HIGH_BAND = 2'h0;            // Divider code for divide by 2
    localparam logic [3:0]  LOCK_SEL_LOCK = 4'h2;
    localparam logic [3:0]  LOCK_SEL_CAL  = 4'h5;
    localparam logic [3:0]  PUMP_RESET    = 4'h8;
    localparam logic [7:0]  LOOP_BW_RESET = 8'h9e;
    localparam int          CLK_HZ        = 20_000_000;
    // Calibration wait times at the lowest reference, in ms
    localparam int          WAIT_MS_0     = 49;
    localparam int          WAIT_MS_1     = 60;
    localparam int          WAIT_MS_2     = 71;
    localparam int          WAIT_MS_3     = 109;
    localparam int          CYC_PER_MS    = CLK_HZ / 1000;

    typedef enum logic [1:0] {SCL_IDLE, SCL_SWEEP, SCL_SETTLE, SCL_DONE} scl_state_e;

    typedef struct packed {
        logic                start;
        logic                dual;
        logic                target_b;
        logic [2:0]          target_volt;
        logic [1:0]          wait_sel;
    } scl_cal_ctrl_s;

    typedef struct packed {
        logic                done;
        logic                locked;
        logic [PUMP_W-1:0]   pump_code;
    } scl_status_s;
endpackage

// ===== scl_result_mem.sv
// Two-entry calibration result store, one per frequency set
`timescale 1ns/1ns
`default_nettype none
module scl_result_mem #(
    parameter int W = 4
) (
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic         wr_en,
    input  wire logic         wr_both,
    input  wire logic         wr_sel,
    input  wire logic [W-1:0] wr_data,
    input  wire logic         rd_sel,
    output logic      [W-1:0] rd_data
);
    logic [W-1:0] mem_reg [2];

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            mem_reg[0] <= W'(scl_pkg::PUMP_RESET);
            mem_reg[1] <= W'(scl_pkg::PUMP_RESET);
            rd_data    <= W'(scl_pkg::PUMP_RESET);
        end else begin
            if (wr_en && (wr_both || !wr_sel)) mem_reg[0] <= wr_data;
            if (wr_en && (wr_both || wr_sel))  mem_reg[1] <= wr_data;
            rd_data <= mem_reg[rd_sel];
        end
    end
endmodule // scl_result_mem
`default_nettype wire

// ===== scl_synth_ctrl.sv
// Synthesizer band, frequency word and self-calibration sequencer
`timescale 1ns/1ns
`default_nettype none
module scl_synth_ctrl #(
    parameter int WAIT_CYC_0 = scl_pkg::WAIT_MS_0 * scl_pkg::CYC_PER_MS,
    parameter int WAIT_CYC_1 = scl_pkg::WAIT_MS_1 * scl_pkg::CYC_PER_MS,
    parameter int WAIT_CYC_2 = scl_pkg::WAIT_MS_2 * scl_pkg::CYC_PER_MS,
    parameter int WAIT_CYC_3 = scl_pkg::WAIT_MS_3 * scl_pkg::CYC_PER_MS
) (
    input  wire logic                          clk,
    input  wire logic                          reset_n,
    input  wire logic                          band_choice_bit,
    input  wire logic [scl_pkg::WORD_W-1:0]    synth_word,
    input  wire logic                          fractional_bit_a,
    input  wire logic                          active_set_b,
    input  wire scl_pkg::scl_cal_ctrl_s        cal_ctrl,
    input  wire logic [scl_pkg::SWEEP_W-1:0]   vco_sensitivity,
    input  wire logic                          pll_phase_locked,
    input  wire logic [7:0]                    loop_bw_setting,
    input  wire logic [3:0]                    lock_pin_sel,
    output scl_pkg::scl_status_s               status,
    output logic [scl_pkg::WORD_W+1:0]         vco_mult_word,
    output logic [1:0]                         out_div_shift,
    output logic [2:0]                         vco_target_voltage_sel,
    output logic [7:0]                         loop_gain_code,
    output logic                               cal_busy,
    output logic                               lock_pin
);
    scl_pkg::scl_state_e      state_reg, state_next;
    logic [31:0]              cnt_reg, cnt_next;
    logic                     done_reg, locked_reg, busy_reg, pin_reg;
    logic                     set_reg, dual_reg;
    logic [scl_pkg::WORD_W+1:0] mult_reg;
    logic [1:0]               div_reg;
    logic [2:0]               tgt_reg;
    logic [7:0]               gain_reg;
    logic [3:0]               pump_sel;
    logic [3:0]               pump_rd;
    logic                     wr_en;

    // Wait in cycles for a two-bit code
    function automatic logic [31:0] wait_cycles(input logic [1:0] code);
        case (code)
            2'h0:    wait_cycles = 32'(WAIT_CYC_0);
            2'h1:    wait_cycles = 32'(WAIT_CYC_1);
            2'h2:    wait_cycles = 32'(WAIT_CYC_2);
            default: wait_cycles = 32'(WAIT_CYC_3);
        endcase
    endfunction

    assign pump_sel = ~vco_sensitivity;
    assign wr_en    = (state_reg == scl_pkg::SCL_DONE);

    scl_result_mem #(.W(scl_pkg::PUMP_W)) u_mem (
        .clk     (clk),
        .reset_n (reset_n),
        .wr_en   (wr_en),
        .wr_both (dual_reg),
        .wr_sel  (set_reg),
        .wr_data (pump_sel),
        .rd_sel  (active_set_b),
        .rd_data (pump_rd)
    );

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        case (state_reg)
            scl_pkg::SCL_IDLE: begin
                if (cal_ctrl.start) begin
                    state_next = scl_pkg::SCL_SWEEP;
                    cnt_next   = wait_cycles(cal_ctrl.wait_sel);
                end
            end
            scl_pkg::SCL_SWEEP: begin
                state_next = scl_pkg::SCL_SETTLE;
            end
            scl_pkg::SCL_SETTLE: begin
                if (cnt_reg <= 32'h2) state_next = scl_pkg::SCL_DONE;
                else cnt_next = cnt_reg - 32'h1;
            end
            default: state_next = scl_pkg::SCL_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_reg <= scl_pkg::SCL_IDLE;
            cnt_reg   <= 32'h0;
            set_reg   <= 1'b0;
            dual_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            // Latched at the take so a host change mid-run cannot misroute the result
            if (state_reg == scl_pkg::SCL_IDLE && cal_ctrl.start) begin
                set_reg  <= cal_ctrl.target_b;
                dual_reg <= cal_ctrl.dual;
            end
        end
    end

    // done flag; a new trigger clears it
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            done_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            busy_reg <= (state_next != scl_pkg::SCL_IDLE);
            if (state_reg == scl_pkg::SCL_DONE) done_reg <= 1'b1;
            else if (state_reg == scl_pkg::SCL_IDLE && cal_ctrl.start) done_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            mult_reg   <= '0;
            div_reg    <= scl_pkg::DIV_HIGH_BAND;
            tgt_reg    <= 3'h0;
            gain_reg   <= scl_pkg::LOOP_BW_RESET;
            locked_reg <= 1'b0;
            pin_reg    <= 1'b0;
        end else begin
            // 6*8192 + 2*word + fractional_bit_a, in half-LSB units
            mult_reg   <= (scl_pkg::WORD_W+2)'(3 << (scl_pkg::FRAC_DEN_LOG2 + 1))
                        + {1'b0, synth_word, fractional_bit_a};
            div_reg    <= band_choice_bit ? scl_pkg::DIV_LOW_BAND : scl_pkg::DIV_HIGH_BAND;
            tgt_reg    <= cal_ctrl.target_volt;
            gain_reg   <= loop_bw_setting;
            locked_reg <= pll_phase_locked && !busy_reg;
            if (lock_pin_sel == scl_pkg::LOCK_SEL_CAL) pin_reg <= done_reg;
            else if (lock_pin_sel == scl_pkg::LOCK_SEL_LOCK) pin_reg <= locked_reg;
            else pin_reg <= 1'b0;
        end
    end

    assign status           = '{done: done_reg, locked: locked_reg, pump_code: pump_rd};
    assign vco_mult_word    = mult_reg;
    assign out_div_shift    = div_reg;
    assign vco_target_voltage_sel = tgt_reg;
    assign loop_gain_code   = gain_reg;
    assign cal_busy         = busy_reg;
    assign lock_pin         = pin_reg;

    // Calibration steps: the take in idle, then the finishing state
    sequence s_take;
        state_reg == scl_pkg::SCL_IDLE && cal_ctrl.start;
    endsequence
    sequence s_finish;
        state_reg == scl_pkg::SCL_DONE;
    endsequence

    a_done_sets: assert property (@(posedge clk) disable iff (!reset_n)
        s_finish |=> status.done)
        else $error("done flag not set");
    a_done_clears: assert property (@(posedge clk) disable iff (!reset_n)
        s_take |=> !status.done)
        else $error("done flag not cleared");
    a_busy_hold: assert property (@(posedge clk) disable iff (!reset_n)
        (busy_reg && !status.done) |=> !status.done || !busy_reg)
        else $error("done during busy");
    a_band_div: assert property (@(posedge clk) disable iff (!reset_n)
        band_choice_bit |=> out_div_shift == scl_pkg::DIV_LOW_BAND)
        else $error("band divider wrong");
    a_pin_cal: assert property (@(posedge clk) disable iff (!reset_n)
        (lock_pin_sel == scl_pkg::LOCK_SEL_CAL) |=> lock_pin == $past(done_reg))
        else $error("lock pin not done flag");
    a_pin_lock: assert property (@(posedge clk) disable iff (!reset_n)
        (lock_pin_sel == scl_pkg::LOCK_SEL_LOCK) |=> lock_pin == $past(locked_reg))
        else $error("lock pin not lock flag");
    a_mult_word: assert property (@(posedge clk) disable iff (!reset_n)
        1'b1 |=> vco_mult_word[0] == $past(fractional_bit_a))
        else $error("fractional_bit_a lsb wrong");
    a_cal_start: assert property (@(posedge clk) disable iff (!reset_n)
        s_take |=> ##1 cal_busy)
        else $error("calibration did not start");
    a_target_sel: assert property (@(posedge clk) disable iff (!reset_n)
        1'b1 |=> vco_target_voltage_sel == $past(cal_ctrl.target_volt))
        else $error("target voltage not passed");
    a_bw_follow: assert property (@(posedge clk) disable iff (!reset_n)
        1'b1 |=> loop_gain_code == $past(loop_bw_setting))
        else $error("loop bandwidth not applied");
endmodule // scl_synth_ctrl
`default_nettype wire

// ===== scl_pll_model.sv
// Stand-in for the analog loop: reports lock after calibration ends
`timescale 1ns/1ns
`default_nettype none
module scl_pll_model (
    input  wire logic clk,
    input  wire logic cal_busy,
    input  wire logic fail_next,
    output logic      pll_phase_locked
);
    logic [1:0] dly_reg;
    initial begin
        dly_reg = 2'h0;
        pll_phase_locked = 1'b0;
    end
    // Lock is lost during calibration, comes back 4 cycles after busy drops unless told to fail
    always @(posedge clk) begin
        if (cal_busy) begin
            dly_reg <= 2'h0;
            pll_phase_locked <= 1'b0;
        end else if (dly_reg != 2'h3) begin
            dly_reg <= dly_reg + 2'h1;
        end else begin
            pll_phase_locked <= !fail_next;
        end
    end
endmodule // scl_pll_model
`default_nettype wire

// ===== testbench.sv
// Self-checking bench for the synthesizer calibration control
`timescale 1ns/1ns
`default_nettype none
module testbench;
    localparam int W0 = 12, W1 = 20, W2 = 28, W3 = 36;
    logic clk, reset_n, band, frac, set_b, fail_next, locked_in, busy, pin;
    logic [15:0] word;
    logic [3:0] sens, sel;
    logic [7:0] bw, gain;
    logic [17:0] mult;
    logic [1:0] shift;
    logic [2:0] tv;
    scl_pkg::scl_cal_ctrl_s cc;
    scl_pkg::scl_status_s st;
    int fail_count, cmp_count, n;
    scl_synth_ctrl #(.WAIT_CYC_0(W0), .WAIT_CYC_1(W1), .WAIT_CYC_2(W2), .WAIT_CYC_3(W3)) dut (
        .clk(clk), .reset_n(reset_n), .band_choice_bit(band), .synth_word(word),
        .fractional_bit_a(frac), .active_set_b(set_b), .cal_ctrl(cc), .vco_sensitivity(sens),
        .pll_phase_locked(locked_in), .loop_bw_setting(bw), .lock_pin_sel(sel), .status(st),
        .vco_mult_word(mult), .out_div_shift(shift), .vco_target_voltage_sel(tv),
        .loop_gain_code(gain), .cal_busy(busy), .lock_pin(pin));
    scl_pll_model pll (.clk(clk), .cal_busy(busy), .fail_next(fail_next), .pll_phase_locked(locked_in));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic summarize;
        $display("compares=%0d mismatches=%0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // One calibration; n counts cycles from the take until done shows
    task automatic cal(input logic [1:0] ws, input logic du, input logic tb_, input logic [3:0] s, input logic refuse);
        @(negedge clk);
        cc = '{start: 1'b1, dual: du, target_b: tb_, target_volt: 3'h0, wait_sel: ws};
        sens = s;
        @(negedge clk);
        cc.start = refuse;
        chk({st.done, busy}, 2'b01);
        n = 1;
        while (st.done !== 1'b1 && n < 200) begin
            @(negedge clk);
            cc.start = 1'b0;
            n++;
        end
        repeat (3) @(negedge clk);
    endtask
    task automatic t_synth_word;
        logic [15:0] wl [3] = '{16'h0000, 16'h1234, 16'hffff};
        for (int i = 0; i < 6; i++) begin
            band = i[0];
            frac = i[1];
            word = wl[i / 2];
            repeat (3) @(negedge clk);
            chk(shift, band ? scl_pkg::DIV_LOW_BAND : scl_pkg::DIV_HIGH_BAND);
            chk(mult, 18'd49152 + {1'b0, word, 1'b0} + frac);
        end
    endtask
    task automatic t_wait;
        int wl [4] = '{W0, W1, W2, W3};
        for (int i = 0; i < 4; i++) begin
            cal(i[1:0], 1'b0, 1'b0, 4'h3, 1'b0);
            chk(n >= wl[i] && n <= wl[i] + 4, 1);
        end
    endtask
    task automatic t_sets;
        cal(2'h0, 1'b0, 1'b0, 4'h3, 1'b0);
        cal(2'h0, 1'b0, 1'b1, 4'h9, 1'b0);
        set_b = 1'b0;
        repeat (2) @(negedge clk);
        chk(st.pump_code, 4'hc);
        set_b = 1'b1;
        repeat (2) @(negedge clk);
        chk(st.pump_code, 4'h6);
        cal(2'h0, 1'b1, 1'b0, 4'h5, 1'b0);
        chk(st.pump_code, 4'ha);
        set_b = 1'b0;
        repeat (2) @(negedge clk);
        chk(st.pump_code, 4'ha);
        cal(2'h1, 1'b0, 1'b0, 4'h1, 1'b1);
        chk(n >= W1 && n <= W1 + 4, 1);
    endtask
    task automatic t_pin;
        fail_next = 1'b1;
        sel = scl_pkg::LOCK_SEL_CAL;
        cal(2'h3, 1'b0, 1'b0, 4'h2, 1'b0);
        chk(pin, 1'b1);
        sel = scl_pkg::LOCK_SEL_LOCK;
        repeat (6) @(negedge clk);
        chk({pin, st.locked}, 2'b00);
        fail_next = 1'b0;
        // Recalibrate until lock is reported
        for (int k = 0; k < 3 && st.locked !== 1'b1; k++) begin
            cal(2'h3, 1'b0, 1'b0, 4'h2, 1'b0);
            repeat (6) @(negedge clk);
        end
        chk({pin, st.locked}, 2'b11);
        sel = 4'h7;
        repeat (2) @(negedge clk);
        chk(pin, 1'b0);
    endtask
    task automatic t_misc;
        logic [7:0] prev;
        for (int i = 0; i < 8; i++) begin
            cc.target_volt = i[2:0];
            bw = 8'h10 * i[7:0] + 8'h10;
            repeat (3) @(negedge clk);
            chk(tv, i[2:0]);
            chk(gain, bw);
            if (i > 0) chk(gain > prev, 1);
            prev = gain;
        end
    endtask
    // Reset in mid-calibration must drop busy; the sequencer then runs again
    task automatic t_reset;
        cc.start = 1'b1;
        @(negedge clk);
        cc.start = 1'b0;
        repeat (3) @(negedge clk);
        chk(busy, 1'b1);
        reset_n = 1'b0;
        repeat (2) @(negedge clk);
        chk({st.done, busy, st.pump_code, st.locked}, {2'b00, scl_pkg::PUMP_RESET, 1'b0});
        reset_n = 1'b1;
        repeat (2) @(negedge clk);
        chk({st.done, busy}, 2'b00);
        cal(2'h0, 1'b0, 1'b0, 4'h3, 1'b0);
        chk(n >= W0 && n <= W0 + 4, 1);
    endtask
    initial begin
        fail_count = 0;
        cmp_count = 0;
        reset_n = 1'b0;
        band = 1'b0;
        frac = 1'b0;
        set_b = 1'b0;
        fail_next = 1'b0;
        word = 16'h0000;
        sens = 4'h0;
        sel = 4'h0;
        bw = scl_pkg::LOOP_BW_RESET;
        cc = '0;
        repeat (6) @(negedge clk);
        chk({st.done, busy, st.pump_code, pin, st.locked, shift, gain, tv},
            {2'b00, scl_pkg::PUMP_RESET, 2'b00, scl_pkg::DIV_HIGH_BAND, scl_pkg::LOOP_BW_RESET, 3'h0});
        reset_n = 1'b1;
        t_synth_word();
        t_wait();
        t_sets();
        t_pin();
        t_misc();
        t_reset();
        summarize();
    end
    // Whole run needs roughly 400 cycles
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        summarize();
    end
endmodule // testbench
`default_nettype wire
